//--- logic/rslc_judge.sv
// digital limit comparator with mantissa/exponent scaling
`timescale 1ns/100ps
module rslc_judge #(
  parameter int MW = rslc_pkg::MANT_W,
  parameter int EW = rslc_pkg::EXP_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 meas_valid,
  input  wire logic signed [MW-1:0] meas_mant,
  input  wire logic signed [EW-1:0] meas_exp,
  input  wire logic                 meas_db_err,
  input  wire logic                 comp_en,
  input  wire logic signed [MW-1:0] hi_mant,
  input  wire logic signed [EW-1:0] hi_exp,
  input  wire logic signed [MW-1:0] lo_mant,
  input  wire logic signed [EW-1:0] lo_exp,
  output logic                      judge_valid,
  output logic                      judge_hi,
  output logic                      judge_pass,
  output logic                      judge_lo
);
  import rslc_pkg::*;

  if (MW < MANT_W || MW > 32 || EW < EXP_W || EW > 8)
    $error("rslc_judge: unsupported mantissa or exponent width");

  typedef logic signed [SCL_W-1:0] rslc_scl_t;

  // value scaled to the smallest exponent step
  function automatic rslc_scl_t scale(input logic signed [MW-1:0] m,
                                      input logic signed [EW-1:0] e);
    rslc_scl_t p;
    rslc_scl_t mw;
    mw = SCL_W'(m);
    unique case (int'(e))
      -3:      p = 48'sh1;
      -2:      p = 48'sha;
      -1:      p = 48'sh64;
      0:       p = 48'sh3e8;
      1:       p = 48'sh2710;
      2:       p = 48'sh186a0;
      3:       p = 48'shf4240;
      4:       p = 48'sh989680;
      5:       p = 48'sh5f5e100;
      6:       p = 48'sh3b9aca00;
      default: p = 48'sh0;
    endcase
    scale = SCL_W'(mw * p);
  endfunction

  wire rslc_scl_t meas_s = scale(meas_mant, meas_exp);
  wire rslc_scl_t hi_s   = scale(hi_mant, hi_exp);
  wire rslc_scl_t lo_s   = scale(lo_mant, lo_exp);
  wire            above  = meas_s > hi_s;
  wire            below  = meas_s < lo_s;
  wire            take   = meas_valid & comp_en & ~meas_db_err;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      judge_valid <= 1'b0;
      judge_hi    <= 1'b0;
      judge_pass  <= 1'b1;
      judge_lo    <= 1'b0;
    end else begin
      judge_valid <= take;
      if (take) begin
        judge_hi   <= above;
        judge_lo   <= ~above & below;
        judge_pass <= ~above & ~below;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_judge_high;
    take && above |=> judge_hi && !judge_pass && !judge_lo;
  endproperty
  a_judge_high: assert property (p_judge_high)
    else $error("result above upper limit not judged high");

  property p_judge_pass;
    take && !above && !below |=> judge_pass;
  endproperty
  a_judge_pass: assert property (p_judge_pass)
    else $error("result inside limits not judged pass");

  property p_db_hold;
    meas_valid && meas_db_err |=>
      $stable({judge_hi, judge_pass, judge_lo}) && !judge_valid;
  endproperty
  a_db_hold: assert property (p_db_hold)
    else $error("decibel error changed the comparison result");

endmodule

//--- logic/rslc_pkg.sv
// constants, types and decode helpers for the remote setting and limit compare
// Contract
// - discard a remote code that is not permitted; keep the present setting
// - speed bits b,a decode 01 fast, 10 medium, 11 slow
// - hold, null, compare and buzzer lines: true turns on, false turns off
// - remote lines are active low: grounded means true, open means false
// - remote code is latched and applied only on the strobe falling edge
// - either of two external start inputs, ORed, starts a sampling cycle
// - result above upper limit is high, below lower is low, else pass
// - exactly one of high, pass, low outputs is high, the latest result
// - only the isolated output of the current judgment is on, others off
// - an active-low compare-end pulse follows each determined result
// - on a decibel calculation error the previous result is held unchanged
// - buzzer sounds on selectable condition: high, pass, low, high or low
// - limits are a five-digit signed mantissa with a decimal exponent
// - range code 0000 is auto ranging, ascending codes ascending ranges
// - function code selects the function, latched on the same strobe edge
package rslc_pkg;

  // wishbone register byte offsets
  localparam int         ADR_W        = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_HI_LIM   = 8'h04;
  localparam logic [7:0] OFS_LO_LIM   = 8'h08;
  localparam logic [7:0] OFS_SETTING  = 8'h0c;
  localparam logic [7:0] OFS_RESULT   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // limit word layout
  localparam int MANT_W   = 18;
  localparam int EXP_W    = 4;
  localparam int EXP_LSB  = 24;
  localparam int EXP_MIN  = -3;
  localparam int EXP_MAX  = 6;
  localparam int SCL_W    = 48;

  // setting word layout
  localparam int SET_FUNC_LSB = 4;
  localparam int SET_SPD_LSB  = 8;
  localparam int SET_HOLD     = 10;
  localparam int SET_NULL     = 11;
  localparam int SET_COMP     = 12;
  localparam int SET_BEEP     = 13;

  // interrupt status bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_APPLIED  = 0;
  localparam int IRQ_REJECTED = 1;
  localparam int IRQ_JUDGED   = 2;
  localparam int IRQ_SAMPLE   = 3;

  // reset values
  localparam logic [3:0]  RST_RANGE = 4'h0;
  localparam logic [3:0]  RST_FUNC  = 4'h1;
  localparam logic [1:0]  RST_SPEED = 2'h3;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
  localparam logic [3:0]  RST_MASK  = 4'h0;

  // speed codes (b,a)
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [1:0] SPD_MID  = 2'h2;
  localparam logic [1:0] SPD_SLOW = 2'h3;

  // highest permitted range code
  localparam logic [3:0] RANGE_MAX = 4'h9;

  // remote pin vector positions
  localparam int PIN_W     = 17;
  localparam int PIN_SPD   = 8;
  localparam int PIN_HOLD  = 10;
  localparam int PIN_NULL  = 11;
  localparam int PIN_COMP  = 12;
  localparam int PIN_BEEP  = 13;
  localparam int PIN_STB   = 14;
  localparam int PIN_TRG_R = 15;
  localparam int PIN_TRG_D = 16;

  // compare-end pulse width
  localparam int CLK_NS      = 20;
  localparam int JUDGMENT_DONE_N_NS  = 10000;
  localparam int JUDGMENT_DONE_N_CYC = (JUDGMENT_DONE_N_NS + CLK_NS - 1) / CLK_NS;
  localparam int DONE_W      = 9;

  typedef enum logic [1:0] {
    BUZ_HI   = 2'b00,
    BUZ_PASS = 2'b01,
    BUZ_LO   = 2'b11,
    BUZ_HILO = 2'b10
  } rslc_buz_t;

  function automatic logic func_ok(input logic [3:0] code);
    unique case (code)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he: func_ok = 1'b1;
      default:                           func_ok = 1'b0;
    endcase
  endfunction

  function automatic logic speed_ok(input logic [1:0] code);
    speed_ok = (code != 2'h0);
  endfunction

endpackage

//--- logic/rslc_top.sv
// remote setting decode, limit compare and wishbone register file
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module rslc_top (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  // wishbone classic slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [rslc_pkg::ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic      [31:0]                      wb_dat_o,
  output logic                                  wb_ack_o,
  output logic                                  irq,
  // remote connector, all active low
  input  wire logic                             range_code_bit0_n,
  input  wire logic                             range_code_bit1_n,
  input  wire logic                             range_code_bit2_n,
  input  wire logic                             range_code_bit3_n,
  input  wire logic                             func_code_bit0_n,
  input  wire logic                             func_code_bit1_n,
  input  wire logic                             func_code_bit2_n,
  input  wire logic                             func_code_bit3_n,
  input  wire logic                             sample_speed_bit_a,
  input  wire logic                             sample_speed_bit_b,
  input  wire logic                             hold_on_n,
  input  wire logic                             null_on_n,
  input  wire logic                             compare_on_n,
  input  wire logic                             beeper_on_n,
  input  wire logic                             strobe_n,
  input  wire logic                             ext_trigger_remote_n,
  input  wire logic                             ext_trigger_dataport_n,
  // measurement result from the converter
  input  wire logic                             meas_valid,
  input  wire logic signed [rslc_pkg::MANT_W-1:0] meas_mant,
  input  wire logic signed [rslc_pkg::EXP_W-1:0]  meas_exp,
  input  wire logic                             meas_db_err,
  // applied settings and the sampling start pulse
  output logic      [3:0]                       range_sel,
  output logic      [3:0]                       func_sel,
  output logic      [1:0]                       speed_sel,
  output logic                                  hold_en,
  output logic                                  null_en,
  output logic                                  comp_en,
  output logic                                  beeper_en,
  output logic                                  sample_start,
  // comparison outputs
  output logic                                  cmp_hi,
  output logic                                  cmp_pass,
  output logic                                  cmp_lo,
  output logic                                  relay_hi_on,
  output logic                                  relay_pass_on,
  output logic                                  relay_lo_on,
  output logic                                  judgment_done_n,
  output logic                                  buzzer
);
  import rslc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser and edge detection

  logic [PIN_W-1:0] pins_n;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic             stb_prev_q;
  logic             trg_prev_q;

  assign pins_n = {ext_trigger_dataport_n, ext_trigger_remote_n, strobe_n,
                   beeper_on_n, compare_on_n, null_on_n, hold_on_n,
                   sample_speed_bit_b, sample_speed_bit_a,
                   func_code_bit3_n, func_code_bit2_n,
                   func_code_bit1_n, func_code_bit0_n,
                   range_code_bit3_n, range_code_bit2_n,
                   range_code_bit1_n, range_code_bit0_n};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_n;
      sync2_q <= sync1_q;
    end
  end

  // grounded line reads as true
  wire [PIN_W-1:0] pin_true  = ~sync2_q;
  wire [3:0]       range_in  = pin_true[3:0];
  wire [3:0]       func_in   = pin_true[7:4];
  wire [1:0]       speed_in  = pin_true[PIN_SPD+1:PIN_SPD];
  wire             trg_any   = pin_true[PIN_TRG_R] | pin_true[PIN_TRG_D];
  wire             stb_fall  = pin_true[PIN_STB] & ~stb_prev_q;
  wire             trg_rise  = trg_any & ~trg_prev_q;
  wire             range_ok  = range_in <= RANGE_MAX;
  wire             f_ok      = func_ok(func_in);
  wire             s_ok      = speed_ok(speed_in);
  wire             rejected  = stb_fall & ~(range_ok & f_ok & s_ok);

  ////////////////////////////////////////////////////////////////////////////
  // remote settings

  logic [3:0] range_q;
  logic [3:0] func_q;
  logic [1:0] speed_q;
  logic       hold_q;
  logic       null_q;
  logic       comp_q;
  logic       beep_q;
  logic       start_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_prev_q <= 1'b0;
      trg_prev_q <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      stb_prev_q <= pin_true[PIN_STB];
      trg_prev_q <= trg_any;
      start_q    <= trg_rise;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      range_q <= RST_RANGE;
      func_q  <= RST_FUNC;
      speed_q <= RST_SPEED;
      hold_q  <= 1'b0;
      null_q  <= 1'b0;
      comp_q  <= 1'b0;
      beep_q  <= 1'b0;
    end else if (stb_fall) begin
      if (range_ok) range_q <= range_in;
      if (f_ok) func_q <= func_in;
      if (s_ok) speed_q <= speed_in;
      hold_q <= pin_true[PIN_HOLD];
      null_q <= pin_true[PIN_NULL];
      comp_q <= pin_true[PIN_COMP];
      beep_q <= pin_true[PIN_BEEP];
    end
  end

  assign range_sel    = range_q;
  assign func_sel     = func_q;
  assign speed_sel    = speed_q;
  assign hold_en      = hold_q;
  assign null_en      = null_q;
  assign comp_en      = comp_q;
  assign beeper_en    = beep_q;
  assign sample_start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // comparator, compare-end pulse, buzzer

  logic [31:0]       ctrl_q;
  logic [31:0]       hi_lim_q;
  logic [31:0]       lo_lim_q;
  logic              judge_valid;
  logic [DONE_W-1:0] done_cnt_q;
  logic              done_n_q;
  logic              buzz_q;

  rslc_judge #(.MW(MANT_W), .EW(EXP_W)) u_judge (
    .clk         (clk),
    .rst_b       (rst_b),
    .meas_valid  (meas_valid),
    .meas_mant   (meas_mant),
    .meas_exp    (meas_exp),
    .meas_db_err (meas_db_err),
    .comp_en     (comp_q),
    .hi_mant     (hi_lim_q[MANT_W-1:0]),
    .hi_exp      (hi_lim_q[EXP_LSB+EXP_W-1:EXP_LSB]),
    .lo_mant     (lo_lim_q[MANT_W-1:0]),
    .lo_exp      (lo_lim_q[EXP_LSB+EXP_W-1:EXP_LSB]),
    .judge_valid (judge_valid),
    .judge_hi    (cmp_hi),
    .judge_pass  (cmp_pass),
    .judge_lo    (cmp_lo)
  );

  // isolated outputs follow the logic outputs one to one
  assign relay_hi_on   = cmp_hi;
  assign relay_pass_on = cmp_pass;
  assign relay_lo_on   = cmp_lo;

  wire rslc_buz_t buz_cond = rslc_buz_t'(ctrl_q[1:0]);
  logic           buz_hit;
  always_comb begin
    unique case (buz_cond)
      BUZ_HI:   buz_hit = cmp_hi;
      BUZ_PASS: buz_hit = cmp_pass;
      BUZ_LO:   buz_hit = cmp_lo;
      BUZ_HILO: buz_hit = cmp_hi | cmp_lo;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_cnt_q <= '0;
      done_n_q   <= 1'b1;
      buzz_q     <= 1'b0;
    end else begin
      done_n_q <= ~(judge_valid | (done_cnt_q != '0));
      if (judge_valid)
        done_cnt_q <= DONE_W'(JUDGMENT_DONE_N_CYC - 1);
      else if (done_cnt_q != '0)
        done_cnt_q <= done_cnt_q - 1'b1;
      buzz_q <= beep_q & comp_q & buz_hit;
    end
  end

  assign judgment_done_n = done_n_q;
  assign buzzer          = buzz_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone register file and interrupt

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic             ack_q;
  logic [31:0]      rdat_q;

  wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wr       = req & wb_we_i;
  wire        rd       = req & ~wb_we_i;
  wire        sel_ctrl = wb_adr_i == OFS_CTRL;
  wire        sel_hi   = wb_adr_i == OFS_HI_LIM;
  wire        sel_lo   = wb_adr_i == OFS_LO_LIM;
  wire        sel_mask = wb_adr_i == OFS_IRQ_MASK;
  wire        sel_stat = wb_adr_i == OFS_IRQ_STAT;
  wire [31:0] setting  = 32'({beep_q, comp_q, null_q, hold_q,
                              speed_q, func_q, range_q});
  wire [31:0] result   = 32'({cmp_lo, cmp_pass, cmp_hi});
  wire [31:0] rd_word  =
      sel_ctrl                  ? ctrl_q               :
      sel_hi                    ? hi_lim_q             :
      sel_lo                    ? lo_lim_q             :
      wb_adr_i == OFS_SETTING   ? setting              :
      wb_adr_i == OFS_RESULT    ? result               :
      sel_stat                  ? 32'(stat_q)          :
      sel_mask                  ? 32'(mask_q)          : 32'h0000_0000;
  wire [IRQ_W-1:0] ev  = {start_q, judge_valid, rejected, stb_fall & ~rejected};
  wire [IRQ_W-1:0] clr = (rd & sel_stat) ? '1 : '0;
  wire [31:0] lim_msk  = 32'((1 << (EXP_LSB + EXP_W)) - (1 << EXP_LSB)) |
                         32'((1 << MANT_W) - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q    <= 1'b0;
      rdat_q   <= '0;
      ctrl_q   <= '0;
      hi_lim_q <= RST_LIMIT;
      lo_lim_q <= RST_LIMIT;
      mask_q   <= RST_MASK;
      stat_q   <= '0;
    end else begin
      ack_q  <= req;
      rdat_q <= rd ? rd_word : rdat_q;
      if (wr & sel_ctrl)
        ctrl_q <= wmerge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
      if (wr & sel_hi)
        hi_lim_q <= wmerge(hi_lim_q, wb_dat_i, wb_sel_i) & lim_msk;
      if (wr & sel_lo)
        lo_lim_q <= wmerge(lo_lim_q, wb_dat_i, wb_sel_i) & lim_msk;
      if (wr & sel_mask & wb_sel_i[0])
        mask_q <= wb_dat_i[IRQ_W-1:0];
      stat_q <= (stat_q & ~clr) | ev;  // set wins over read-clear
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq      = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_latch_only_on_strobe;
    !$stable({range_q, func_q, speed_q, hold_q}) |-> $past(stb_fall);
  endproperty
  a_latch_only_on_strobe: assert property (p_latch_only_on_strobe)
    else $error("setting changed without a strobe fall");

  property p_strobe_synced;
    stb_fall |-> !$past(strobe_n, 2) && $past(strobe_n, 3);
  endproperty
  a_strobe_synced: assert property (p_strobe_synced)
    else $error("strobe edge not two flops behind the pin");

  property p_bad_func_kept;
    stb_fall && !func_ok(func_in) |=> $stable(func_q);
  endproperty
  a_bad_func_kept: assert property (p_bad_func_kept)
    else $error("forbidden function code was applied");

  property p_speed_decode;
    stb_fall && speed_in == SPD_MID |=> speed_sel == SPD_MID;
  endproperty
  a_speed_decode: assert property (p_speed_decode)
    else $error("medium speed code not applied");

  property p_hold_on;
    stb_fall |=> hold_en == !$past(hold_on_n, 3);
  endproperty
  a_hold_on: assert property (p_hold_on)
    else $error("hold setting does not follow the hold line");

  wire trg_pin_any = ~ext_trigger_remote_n | ~ext_trigger_dataport_n;
  property p_ext_start;
    $rose(trg_pin_any) ##1 trg_pin_any [*2] |=> sample_start;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("external start did not start sampling");

  property p_one_result;
    $onehot({cmp_hi, cmp_pass, cmp_lo}) &&
      {relay_hi_on, relay_pass_on, relay_lo_on} == {cmp_hi, cmp_pass, cmp_lo};
  endproperty
  a_one_result: assert property (p_one_result)
    else $error("result outputs not exactly one active");

  property p_done_pulse;
    judge_valid |=> !judgment_done_n [*8];
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("compare-end pulse missing after a judgment");

  property p_buzz_pass;
    beep_q && comp_q && buz_cond == BUZ_PASS && cmp_pass |=> buzzer;
  endproperty
  a_buzz_pass: assert property (p_buzz_pass)
    else $error("buzzer silent on pass condition");

endmodule

//--- tb/rslc_remote_model.sv
// far-side remote controller: grounds lines for true, leaves them open
`timescale 1ns/100ps
module rslc_remote_model (
  input  wire logic       clk,
  output logic      [3:0] range_n,
  output logic      [3:0] func_n,
  output logic      [1:0] speed_n,
  output logic      [3:0] onoff_n,
  output logic            strobe_n,
  output logic      [1:0] trig_n
);
  initial begin
    {range_n, func_n, speed_n, onoff_n, strobe_n, trig_n} = '1;
  end
  //////////////////////////////////////////////////////////////////////////
  // code first, strobe low a cycle later, lines opened with the strobe
  task automatic send(input logic [3:0] r, input logic [3:0] f,
                      input logic [1:0] s, input logic [3:0] o);
    @(posedge clk);
    {range_n, func_n, speed_n, onoff_n} <= ~{r, f, s, o};
    @(posedge clk);
    strobe_n <= 1'b0;
    repeat (3) @(posedge clk);
    {range_n, func_n, speed_n, onoff_n, strobe_n} <= '1;
    repeat (3) @(posedge clk);
  endtask
  task automatic start(input int i, input int w);
    @(posedge clk);
    trig_n[i] <= 1'b0;
    repeat (w) @(posedge clk);
    trig_n[i] <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- tb/rslc_top_test.sv
// self-checking bench for the remote setting and limit compare
`timescale 1ns/100ps
module rslc_top_test;
  import rslc_pkg::*;
  logic clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q, es;
  logic meas_valid = 0, meas_db_err = 0, wb_ack_o, irq, hold_en, null_en;
  logic signed [MANT_W-1:0] meas_mant = 0;
  logic signed [EXP_W-1:0] meas_exp = 0;
  logic [2:0] cap;
  logic signed [MANT_W-1:0] vals [3] = '{18'sd101, 18'sd100, -18'sd101};
  logic [3:0] range_sel, func_sel, rn, fn, on_n;
  logic [1:0] speed_sel, sn, tn;
  logic comp_en, beeper_en, sample_start, cmp_hi, cmp_pass, cmp_lo, sb_n;
  logic relay_hi_on, relay_pass_on, relay_lo_on, judgment_done_n, buzzer;
  int n_errors = 0, compares = 0, n_start = 0, low_cnt = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (sample_start === 1'b1) n_start++;
    if (judgment_done_n === 1'b0) begin
      low_cnt++;
      cap = {cmp_hi, cmp_pass, cmp_lo};
    end
  end
  rslc_remote_model m (.clk, .range_n(rn), .func_n(fn), .speed_n(sn),
    .onoff_n(on_n), .strobe_n(sb_n), .trig_n(tn));
  rslc_top dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
    .range_code_bit0_n(rn[0]), .range_code_bit1_n(rn[1]),
    .range_code_bit2_n(rn[2]), .range_code_bit3_n(rn[3]),
    .func_code_bit0_n(fn[0]), .func_code_bit1_n(fn[1]),
    .func_code_bit2_n(fn[2]), .func_code_bit3_n(fn[3]),
    .sample_speed_bit_a(sn[0]), .sample_speed_bit_b(sn[1]),
    .hold_on_n(on_n[0]), .null_on_n(on_n[1]), .compare_on_n(on_n[2]),
    .beeper_on_n(on_n[3]), .strobe_n(sb_n), .ext_trigger_remote_n(tn[0]),
    .ext_trigger_dataport_n(tn[1]), .meas_valid, .meas_mant,
    .meas_exp, .meas_db_err, .range_sel, .func_sel, .speed_sel,
    .hold_en, .null_en, .comp_en, .beeper_en, .sample_start, .cmp_hi,
    .cmp_pass, .cmp_lo, .relay_hi_on, .relay_pass_on, .relay_lo_on,
    .judgment_done_n, .buzzer);
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk({31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic meas(input logic signed [MANT_W-1:0] v,
                      input logic [EXP_W-1:0] x, input logic e);
    @(posedge clk);
    {meas_valid, meas_mant, meas_exp, meas_db_err} <= {1'b1, v, x, e};
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic buz_exp(input logic [1:0] c, input int i);
    case (c)
      2'b00: buz_exp = (i == 0);
      2'b01: buz_exp = (i == 1);
      2'b11: buz_exp = (i == 2);
      default: buz_exp = (i != 1);
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_SETTING, 32'h0000_0310);
    rd(OFS_RESULT, 32'h2);
    rd(8'h1c, 32'h0);
    for (int s = 1; s < 4; s++) begin
      m.send(4'h9, 4'he, s[1:0], 4'b0101);
      es = {18'h0, 4'b0101, s[1:0], 4'he, 4'h9};
      rd(OFS_SETTING, es);
      chk({18'h0, beeper_en, comp_en, null_en, hold_en, speed_sel,
           func_sel, range_sel}, es);
    end
    m.send(4'ha, 4'ha, 2'h0, 4'b1100);
    es = {18'h0, 4'b1100, 2'h3, 4'he, 4'h9};
    rd(OFS_SETTING, es);
    wb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h3);
    wb(1'b1, OFS_SETTING, 32'h0);
    rd(OFS_SETTING, es);
    wb(1'b1, OFS_IRQ_MASK, 32'h8);
    m.start(0, 5000);
    chk(n_start, 1);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFS_IRQ_MASK, 32'h0);
    m.start(1, 5000);
    chk(n_start, 2);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFS_HI_LIM, 32'h0000_0064);
    wb(1'b1, OFS_LO_LIM, 32'hf0f3_ff9c);
    rd(OFS_LO_LIM, 32'h0003_ff9c);
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, OFS_CTRL, 32'(c));
        meas(vals[i], 4'h0, 1'b0);
        chk(cap, 3'b100 >> i);
        chk({cmp_hi, cmp_pass, cmp_lo, relay_hi_on, relay_pass_on,
             relay_lo_on}, {2{3'b100 >> i}});
        chk({31'h0, buzzer}, {31'h0, buz_exp(c[1:0], i)});
      end
    end
    meas(18'sd101, 4'hf, 1'b0);
    chk({cmp_hi, cmp_pass, cmp_lo}, 3'b010);
    meas(18'sd1, 4'h3, 1'b0);
    chk({cmp_hi, cmp_pass, cmp_lo}, 3'b100);
    meas(-18'sd1, 4'h3, 1'b0);
    chk({cmp_hi, cmp_pass, cmp_lo}, 3'b001);
    rd(OFS_IRQ_STAT, 32'hc);
    repeat (600) @(posedge clk);
    low_cnt = 0;
    meas(18'sd101, 4'h0, 1'b1);
    chk({low_cnt[28:0], cmp_hi, cmp_pass, cmp_lo}, 32'h1);
    meas(18'sd0, 4'h0, 1'b0);
    repeat (600) @(posedge clk);
    chk(low_cnt, 500);
    complete_run();
  end
endmodule
